// File: rtl/timer8_consts.svh
// Constants of the 8-bit timer/event counter: addresses, bit fields,
// reset values and prescaler shift amounts.
// Assumes inclusion by bare name from the design files.
`ifndef TIMER8_CONSTS_SVH
`define TIMER8_CONSTS_SVH

// Register addresses on the special-function register port.
`define ADDR_CLOCK_SELECT 16'hFF6A
`define ADDR_MODE_CONTROL 16'hFF6B
`define ADDR_COUNT_VALUE 16'hFF6C
`define ADDR_COMPARE_VALUE 16'hFF6D

// Field positions of the mode-control register.
`define MODE_EN_BIT 3'h7
`define MODE_PWM_BIT 3'h6
`define MODE_PRESET_SET_BIT 3'h3
`define MODE_PRESET_CLR_BIT 3'h2
`define MODE_INV_BIT 3'h1
`define MODE_OE_BIT 3'h0

// Width of the clock selector field.
`define SEL_WIDTH 3

// Reset values.
`define CLOCK_SELECT_RST 3'h0
`define COUNT_RST 8'h00
`define COMPARE_RST 8'h00
`define RDATA_RST 8'h00

// Clock selector codes.
`define SEL_EVENT_FALL 3'h0
`define SEL_EVENT_RISE 3'h1
`define SEL_DIV1 3'h2
`define SEL_DIV2 3'h3
`define SEL_DIV4 3'h4
`define SEL_DIV64 3'h5
`define SEL_DIV256 3'h6
`define SEL_DIV8192 3'h7

// Prescaler shift amounts (divide ratio is two to this power).
`define SHIFT_DIV1 4'h0
`define SHIFT_DIV2 4'h1
`define SHIFT_DIV4 4'h2
`define SHIFT_DIV64 4'h6
`define SHIFT_DIV256 4'h8
`define SHIFT_DIV8192 4'hD

// Least prescaler width that serves the largest ratio.
`define PRESCALE_WIDTH 13

`endif

// File: rtl/timer8_pkg.sv
// Types of the 8-bit timer/event counter.
// Assumes timer8_consts.svh is on the include path.
`include "timer8_consts.svh"

package timer8_pkg;

    // One access on the special-function register port.
    typedef struct packed {
        logic wr;
        logic bit_wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [2:0] bit_idx;
        logic bit_val;
    } sfr_req_t;

    // Whole state of the timer.
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] compare;
        logic [`SEL_WIDTH-1:0] sel;
        logic en;
        logic pwm;
        logic inv;
        logic oe;
        logic ff;
        logic pin;
        logic irq;
        logic [7:0] rdata;
    } timer_state_t;

    // Whole state of the count-clock prescaler.
    typedef struct packed {
        logic [`PRESCALE_WIDTH-1:0] pre;
        logic event_prev;
    } prescale_state_t;

    typedef enum logic [1:0] {
        PRESET_NONE = 2'h0,
        PRESET_CLEAR = 2'h1,
        PRESET_SET = 2'h2,
        PRESET_BAD = 2'h3
    } preset_t;

endpackage : timer8_pkg

// File: rtl/count_clock_gen.sv
// Count-clock generator: prescaler and event-pin edge detector that give
// a one-cycle count tick for the selected source.
// Assumes the event pin is already synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_consts.svh"

module count_clock_gen #(
    parameter int PRE_WIDTH = `PRESCALE_WIDTH
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [`SEL_WIDTH-1:0] sel,
    input wire logic run,
    input wire logic event_input_pin,
    output logic tick
);
    import timer8_pkg::*;

    generate
        if (PRE_WIDTH < `PRESCALE_WIDTH) begin : g_width_check
            $error("Prescaler too narrow for the largest ratio.");
        end
    endgenerate

    prescale_state_t st_r;
    prescale_state_t st_nxt;
    logic [3:0] shift;
    logic [PRE_WIDTH-1:0] ones;

    always_comb begin
        case (sel)
            `SEL_DIV1: shift = `SHIFT_DIV1;
            `SEL_DIV2: shift = `SHIFT_DIV2;
            `SEL_DIV4: shift = `SHIFT_DIV4;
            `SEL_DIV64: shift = `SHIFT_DIV64;
            `SEL_DIV256: shift = `SHIFT_DIV256;
            default: shift = `SHIFT_DIV8192;
        endcase
    end

    assign ones = {PRE_WIDTH{1'b1}};

    always_comb begin
        st_nxt = st_r;
        st_nxt.event_prev = event_input_pin;
        // The prescaler restarts while stopped so the first period is whole.
        st_nxt.pre = run ? st_r.pre + 1'b1 : '0;
        case (sel)
            `SEL_EVENT_FALL: tick = st_r.event_prev && !event_input_pin;
            `SEL_EVENT_RISE: tick = !st_r.event_prev && event_input_pin;
            default: tick = &(st_r.pre | (ones << shift));
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : count_clock_gen
`default_nettype wire

// File: rtl/timer8_event_counter.sv
// 8-bit timer/event counter with compare, clear-and-start and PWM modes,
// reached through the special-function register port.
// Assumes one access per cycle and synchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_consts.svh"

module timer8_event_counter (
    input wire logic mclk,
    input wire logic nrst,
    input wire timer8_pkg::sfr_req_t sfr_req,
    input wire logic event_input_pin,
    output logic [7:0] sfr_rdata,
    output logic match_irq,
    output logic timer_output_pin
);
    import timer8_pkg::*;

    timer_state_t st_r;
    timer_state_t st_nxt;
    logic tick;
    logic match;
    logic hit_clksel;
    logic hit_mode;
    logic hit_count;
    logic hit_compare;
    logic [7:0] clksel_byte;
    logic [7:0] mode_byte;
    logic [7:0] mode_new;
    logic [7:0] clksel_new;
    logic mode_written;
    preset_t preset;

    count_clock_gen #(
        .PRE_WIDTH(`PRESCALE_WIDTH)
    ) u_clk (
        .mclk(mclk),
        .nrst(nrst),
        .sel(st_r.sel),
        .run(st_r.en),
        .event_input_pin(event_input_pin),
        .tick(tick)
    );

    assign match = (st_r.count == st_r.compare);
    assign hit_clksel = (sfr_req.addr == `ADDR_CLOCK_SELECT);
    assign hit_mode = (sfr_req.addr == `ADDR_MODE_CONTROL);
    assign hit_count = (sfr_req.addr == `ADDR_COUNT_VALUE);
    assign hit_compare = (sfr_req.addr == `ADDR_COMPARE_VALUE);

    // Readable images; preset bits are write-only and read as zero.
    assign clksel_byte = {5'h00, st_r.sel};
    assign mode_byte = {st_r.en, st_r.pwm, 4'h0, st_r.inv, st_r.oe};

    // Result of a byte or single-bit write on top of the readable image.
    function automatic logic [7:0] apply_write(input logic [7:0] old,
                                               input sfr_req_t req);
        logic [7:0] v;
        v = old;
        if (req.wr) begin
            v = req.wdata;
        end else if (req.bit_wr) begin
            v[req.bit_idx] = req.bit_val;
        end
        return v;
    endfunction : apply_write

    assign clksel_new = apply_write(clksel_byte, sfr_req);
    assign mode_new = apply_write(mode_byte, sfr_req);
    assign mode_written = hit_mode && (sfr_req.wr || sfr_req.bit_wr);
    assign preset = mode_written ?
        preset_t'({mode_new[`MODE_PRESET_SET_BIT],
                   mode_new[`MODE_PRESET_CLR_BIT]}) : PRESET_NONE;

    always_comb begin
        st_nxt = st_r;
        st_nxt.irq = 1'b0;

        // Register writes.
        if (hit_clksel && (sfr_req.wr || sfr_req.bit_wr)) begin
            st_nxt.sel = clksel_new[`SEL_WIDTH-1:0];
        end
        if (mode_written) begin
            st_nxt.en = mode_new[`MODE_EN_BIT];
            st_nxt.pwm = mode_new[`MODE_PWM_BIT];
            st_nxt.inv = mode_new[`MODE_INV_BIT];
            st_nxt.oe = mode_new[`MODE_OE_BIT];
        end
        if (hit_compare && sfr_req.wr) begin
            st_nxt.compare = sfr_req.wdata;
        end

        // Counting and compare.
        if (st_r.en && tick) begin
            if (!st_r.pwm && match) begin
                st_nxt.count = 8'h00;
                st_nxt.irq = 1'b1;
                if (st_r.inv) begin
                    st_nxt.ff = !st_r.ff;
                end
            end else begin
                st_nxt.count = st_r.count + 8'h01;
                if (st_r.pwm) begin
                    if (match) begin
                        st_nxt.ff = st_r.inv;
                    end else if (st_r.count == 8'hFF) begin
                        st_nxt.ff = !st_r.inv;
                    end
                end
            end
        end
        if (!st_nxt.en) begin
            st_nxt.count = `COUNT_RST;
        end

        // Preset wins over timer activity; code 11 leaves the flip-flop.
        case (preset)
            PRESET_CLEAR: st_nxt.ff = 1'b0;
            PRESET_SET: st_nxt.ff = 1'b1;
            default: st_nxt.ff = st_nxt.ff;
        endcase

        st_nxt.pin = st_nxt.oe ? st_nxt.ff : 1'b0;

        // Read data, registered one cycle after the strobe.
        if (sfr_req.rd) begin
            if (hit_clksel) begin
                st_nxt.rdata = clksel_byte;
            end else if (hit_mode) begin
                st_nxt.rdata = mode_byte;
            end else if (hit_count) begin
                st_nxt.rdata = st_r.count;
            end else if (hit_compare) begin
                st_nxt.rdata = st_r.compare;
            end else begin
                st_nxt.rdata = `RDATA_RST;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sfr_rdata = st_r.rdata;
    assign match_irq = st_r.irq;
    assign timer_output_pin = st_r.pin;

    // Checks.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    count_stop_a: assert property (
        !st_r.en |-> st_r.count == 8'h00)
        else $error("Counter not zero while disabled.");

    clear_match_a: assert property (
        st_r.en && tick && !st_r.pwm && match |=> st_r.count == 8'h00)
        else $error("Counter not cleared on match.");

    count_inc_a: assert property (
        st_r.en && tick && (st_r.pwm || !match) && !mode_written
        |=> st_r.count == $past(st_r.count) + 8'h01)
        else $error("Counter did not advance on a tick.");

    hold_count_a: assert property (
        st_r.en && !tick && !mode_written |=> $stable(st_r.count))
        else $error("Counter moved without a tick.");

    irq_cause_a: assert property (
        match_irq |-> $past(st_r.en && tick && !st_r.pwm && match))
        else $error("Interrupt without a clear-mode match.");

    irq_match_a: assert property (
        st_r.en && tick && !st_r.pwm && match |=> match_irq)
        else $error("Match did not raise the interrupt.");

    pwm_noirq_a: assert property (
        st_r.pwm && !mode_written |=> !match_irq)
        else $error("Interrupt raised in PWM mode.");

    pwm_inactive_a: assert property (
        st_r.en && st_r.pwm && tick && match && !mode_written
        |=> st_r.ff == st_r.inv)
        else $error("PWM output not inactive after match.");

    pwm_active_a: assert property (
        st_r.en && st_r.pwm && tick && !match && st_r.count == 8'hFF
        && !mode_written |=> st_r.ff != st_r.inv)
        else $error("PWM output not active after wrap.");

    toggle_a: assert property (
        st_r.en && !st_r.pwm && st_r.inv && tick && match && !mode_written
        |=> st_r.ff != $past(st_r.ff))
        else $error("Flip-flop did not toggle on match.");

    preset_a: assert property (
        preset == PRESET_SET |=> st_r.ff)
        else $error("Preset set not applied.");

    preset_clr_a: assert property (
        preset == PRESET_CLEAR |=> !st_r.ff)
        else $error("Preset clear not applied.");

    preset_keep_a: assert property (
        (preset == PRESET_NONE || preset == PRESET_BAD) && !(st_r.en && tick)
        |=> st_r.ff == $past(st_r.ff))
        else $error("Flip-flop moved without preset or tick.");

    out_low_a: assert property (
        !st_r.oe |-> !timer_output_pin)
        else $error("Output not low while disabled.");

    out_follow_a: assert property (
        st_r.oe |-> timer_output_pin == st_r.ff)
        else $error("Output does not follow the flip-flop.");

    sel_upper_a: assert property (
        sfr_req.rd && hit_clksel |=> sfr_rdata[7:3] == 5'h00)
        else $error("Clock select upper bits not zero.");

    compare_wr_a: assert property (
        sfr_req.wr && hit_compare |=> st_r.compare == $past(sfr_req.wdata))
        else $error("Compare write lost.");

    compare_hold_a: assert property (
        !(sfr_req.wr && hit_compare) |=> $stable(st_r.compare))
        else $error("Compare changed without a byte write.");

    // Clock select takes byte and single-bit writes and is otherwise kept.
    sel_byte_a: assert property (
        sfr_req.wr && hit_clksel
        |=> st_r.sel == $past(sfr_req.wdata[`SEL_WIDTH-1:0]))
        else $error("Clock select byte write lost.");

    sel_bit_a: assert property (
        sfr_req.bit_wr && !sfr_req.wr && hit_clksel && sfr_req.bit_idx < 3'h3
        |=> st_r.sel[$past(sfr_req.bit_idx[1:0])] == $past(sfr_req.bit_val))
        else $error("Clock select bit write lost.");

    sel_hold_a: assert property (
        !(hit_clksel && (sfr_req.wr || sfr_req.bit_wr)) |=> $stable(st_r.sel))
        else $error("Clock select changed without a write.");

    // A byte write to the mode register sets enable and mode directly.
    en_bit_a: assert property (
        sfr_req.wr && hit_mode
        |=> st_r.en == $past(sfr_req.wdata[`MODE_EN_BIT]))
        else $error("Count enable write lost.");

    pwm_bit_a: assert property (
        sfr_req.wr && hit_mode
        |=> st_r.pwm == $past(sfr_req.wdata[`MODE_PWM_BIT]))
        else $error("Mode select write lost.");

    rd_count_a: assert property (
        sfr_req.rd && hit_count |=> sfr_rdata == $past(st_r.count))
        else $error("Count read returned a stale value.");

    count_ro_a: assert property (
        sfr_req.wr && hit_count && !(st_r.en && tick)
        |=> $stable(st_r.count))
        else $error("Counter took a write.");

    // Event edges give one tick each; the first cycle after reset is skipped
    // because the edge detector starts from a cleared sample.
    rise_tick_a: assert property (
        $past(nrst) && st_r.sel == `SEL_EVENT_RISE
        |-> tick == $rose(event_input_pin))
        else $error("Rising event edge and tick disagree.");

    fall_tick_a: assert property (
        $past(nrst) && st_r.sel == `SEL_EVENT_FALL
        |-> tick == $fell(event_input_pin))
        else $error("Falling event edge and tick disagree.");

    div1_tick_a: assert property (
        st_r.sel == `SEL_DIV1 |-> tick)
        else $error("Undivided clock missed a tick.");

    div_gap_a: assert property (
        st_r.sel > `SEL_DIV1 && tick
        |=> !tick || st_r.sel != $past(st_r.sel))
        else $error("Prescaled ticks in adjacent cycles.");

endmodule : timer8_event_counter
`default_nettype wire

// File: testbench/event_pin_model.sv
// Far-side model: drives the event input pin, watches the timer output.
// Assumes the bench calls set_level between clock edges.
`timescale 1ns/1ps
`default_nettype none
module event_pin_model (
    input wire logic mclk,
    input wire logic timer_output_pin,
    output logic event_input_pin
);
    int high_cycles = 0;
    initial begin
        event_input_pin = 1'b0;
    end
    // Counts cycles with the output high, so the bench can measure duty.
    always @(posedge mclk) begin
        if (timer_output_pin === 1'b1) begin
            high_cycles <= high_cycles + 1;
        end
    end
    // Each level is held a full cycle so one edge is seen once.
    // The pin only moves while mclk runs.
    task automatic set_level(input logic lvl);
        @(negedge mclk);
        event_input_pin = lvl;
        @(negedge mclk);
    endtask : set_level
endmodule : event_pin_model
`default_nettype wire

// File: testbench/tb_eight_bit_timer_event_counter.sv
// Self-checking bench of the 8-bit timer/event counter.
// Assumes the design and event_pin_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_consts.svh"
module tb_eight_bit_timer_event_counter;
    import timer8_pkg::*;
    localparam logic [15:0] a_sel = `ADDR_CLOCK_SELECT;
    localparam logic [15:0] a_mode = `ADDR_MODE_CONTROL;
    localparam logic [15:0] a_cnt = `ADDR_COUNT_VALUE;
    localparam logic [15:0] a_cmp = `ADDR_COMPARE_VALUE;
    logic mclk;
    logic nrst;
    sfr_req_t sfr_req;
    logic event_input_pin;
    logic [7:0] sfr_rdata;
    logic match_irq;
    logic timer_output_pin;
    int num_errors = 0;
    int compares = 0;
    int cyc;
    logic [7:0] rd_val;

    timer8_event_counter timer8_event_counter_inst (
        .mclk(mclk), .nrst(nrst), .sfr_req(sfr_req),
        .event_input_pin(event_input_pin), .sfr_rdata(sfr_rdata),
        .match_irq(match_irq), .timer_output_pin(timer_output_pin));
    event_pin_model event_pin_model_inst (
        .mclk(mclk), .timer_output_pin(timer_output_pin),
        .event_input_pin(event_input_pin));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic sfr(input logic w, input logic r, input logic [15:0] a,
                       input logic [7:0] d);
        @(negedge mclk);
        sfr_req.wr = w;
        sfr_req.rd = r;
        sfr_req.addr = a;
        sfr_req.wdata = d;
        @(negedge mclk);
        sfr_req.wr = 1'b0;
        sfr_req.rd = 1'b0;
        rd_val = sfr_rdata;
    endtask : sfr

    task automatic sfr_bit(input logic [15:0] a, input logic [2:0] i,
                           input logic v);
        @(negedge mclk);
        sfr_req.bit_wr = 1'b1;
        sfr_req.addr = a;
        sfr_req.bit_idx = i;
        sfr_req.bit_val = v;
        @(negedge mclk);
        sfr_req.bit_wr = 1'b0;
    endtask : sfr_bit

    task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
        sfr(1'b0, 1'b1, a, 8'h00);
        check({8'h00, rd_val}, {8'h00, exp});
    endtask : rd_check

    task automatic pin_check(input logic exp);
        @(negedge mclk);
        check({15'h0000, timer_output_pin}, {15'h0000, exp});
    endtask : pin_check

    // Waits for the next interrupt pulse; cyc holds the cycles it took.
    task automatic wait_irq();
        cyc = 0;
        do begin
            @(negedge mclk);
            cyc++;
        end while (match_irq !== 1'b1 && cyc < 20000);
        if (cyc >= 20000) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, 0, 1);
            finish_test();
        end
    endtask : wait_irq

    task automatic test_regs();
        rd_check(a_sel, 8'h00);
        rd_check(a_mode, 8'h00);
        rd_check(a_cnt, 8'h00);
        rd_check(a_cmp, 8'h00);
        sfr(1'b1, 1'b0, a_sel, 8'hFF);
        rd_check(a_sel, 8'h07);
        sfr_bit(a_sel, 3'h1, 1'b0);
        rd_check(a_sel, 8'h05);
        sfr_bit(a_sel, 3'h6, 1'b1);
        rd_check(a_sel, 8'h05);
        sfr(1'b1, 1'b0, a_cmp, 8'hFF);
        rd_check(a_cmp, 8'hFF);
        sfr(1'b1, 1'b0, a_cnt, 8'h55);
        rd_check(a_cnt, 8'h00);
        rd_check(a_cmp, 8'hFF);
        rd_check(16'hFF00, 8'h00);
    endtask : test_regs

    task automatic test_prescale();
        logic [3:0] sh [6];
        sh = '{`SHIFT_DIV1, `SHIFT_DIV2, `SHIFT_DIV4, `SHIFT_DIV64,
               `SHIFT_DIV256, `SHIFT_DIV8192};
        sfr(1'b1, 1'b0, a_mode, 8'h00);
        sfr(1'b1, 1'b0, a_cmp, 8'h00);
        for (int i = 0; i < 6; i++) begin
            sfr(1'b1, 1'b0, a_mode, 8'h00);
            sfr(1'b1, 1'b0, a_sel, `SEL_DIV1 + 8'(i));
            sfr(1'b1, 1'b0, a_mode, 8'h80);
            wait_irq();
            wait_irq();
            check(cyc[15:0], 16'h0001 << sh[i]);
        end
    endtask : test_prescale

    task automatic test_clear();
        logic p0;
        sfr(1'b1, 1'b0, a_mode, 8'h05);
        sfr(1'b1, 1'b0, a_cmp, 8'h03);
        sfr(1'b1, 1'b0, a_sel, `SEL_DIV1);
        sfr(1'b1, 1'b0, a_mode, 8'h83);
        wait_irq();
        p0 = timer_output_pin;
        wait_irq();
        check(cyc[15:0], 16'h0004);
        check({15'h0000, timer_output_pin}, {15'h0000, ~p0});
        sfr(1'b1, 1'b0, a_mode, 8'h03);
        rd_check(a_cnt, 8'h00);
    endtask : test_clear

    task automatic test_event();
        sfr(1'b1, 1'b0, a_cmp, 8'hFF);
        sfr(1'b1, 1'b0, a_sel, `SEL_EVENT_RISE);
        sfr(1'b1, 1'b0, a_mode, 8'h80);
        event_pin_model_inst.set_level(1'b1);
        event_pin_model_inst.set_level(1'b0);
        event_pin_model_inst.set_level(1'b1);
        rd_check(a_cnt, 8'h02);
        sfr(1'b1, 1'b0, a_mode, 8'h00);
        sfr(1'b1, 1'b0, a_sel, `SEL_EVENT_FALL);
        sfr(1'b1, 1'b0, a_mode, 8'h80);
        event_pin_model_inst.set_level(1'b0);
        event_pin_model_inst.set_level(1'b1);
        rd_check(a_cnt, 8'h01);
    endtask : test_event

    task automatic test_pwm();
        int h0;
        int irqs;
        int hc;
        logic [15:0] exp_hi;
        irqs = 0;
        sfr(1'b1, 1'b0, a_mode, 8'h00);
        sfr(1'b1, 1'b0, a_cmp, 8'h3F);
        sfr(1'b1, 1'b0, a_sel, `SEL_DIV1);
        sfr(1'b1, 1'b0, a_mode, 8'hC1);
        // Active high first, then active low with the same compare value.
        for (int k = 0; k < 2; k++) begin
            exp_hi = (k == 0) ? 16'h0040 : 16'h00C0;
            repeat (300) @(negedge mclk);
            h0 = event_pin_model_inst.high_cycles;
            repeat (256) begin
                @(negedge mclk);
                if (match_irq !== 1'b0) begin
                    irqs++;
                end
            end
            hc = event_pin_model_inst.high_cycles - h0;
            check(hc[15:0], exp_hi);
            sfr(1'b1, 1'b0, a_mode, 8'hC3);
        end
        check(16'(irqs), 16'h0000);
    endtask : test_pwm

    // Reset in mid-run: every register and the pin return to zero.
    task automatic test_reset();
        sfr(1'b1, 1'b0, a_cmp, 8'h5A);
        sfr(1'b1, 1'b0, a_mode, 8'h89);
        pin_check(1'b1);
        nrst = 1'b0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        pin_check(1'b0);
        rd_check(a_cmp, 8'h00);
        rd_check(a_sel, 8'h00);
        rd_check(a_mode, 8'h00);
        rd_check(a_cnt, 8'h00);
    endtask : test_reset

    task automatic test_preset();
        sfr(1'b1, 1'b0, a_mode, 8'h09);
        pin_check(1'b1);
        rd_check(a_mode, 8'h01);
        sfr(1'b1, 1'b0, a_mode, 8'h05);
        pin_check(1'b0);
        sfr(1'b1, 1'b0, a_mode, 8'h09);
        sfr(1'b1, 1'b0, a_mode, 8'h01);
        pin_check(1'b1);
        sfr(1'b1, 1'b0, a_mode, 8'h00);
        pin_check(1'b0);
    endtask : test_preset

    initial begin
        nrst = 1'b0;
        sfr_req = '0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        test_regs();
        test_preset();
        test_clear();
        test_event();
        test_prescale();
        test_pwm();
        test_reset();
        finish_test();
    end
endmodule : tb_eight_bit_timer_event_counter
`default_nettype wire
